// ---- logic/hs_switch_ctrl.sv ----
// Module: high-side switch control with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module hs_switch_ctrl #(
  parameter int OL_CYC  = hs_pkg::OL_CYC,
  parameter int TMR_DIV = hs_pkg::TMR_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic        uv_i,
  input  wire logic        ov_i,
  input  wire logic [3:0]  oc_i,
  input  wire logic [3:0]  ol_i,
  input  wire logic        sync_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [3:0]       hs_on_o,
  output logic             wake_en_o
);
  logic [10:0]      pin_meta_r;
  logic [10:0]      pin_r;
  logic             uv_s;
  logic             ov_s;
  logic [3:0]       oc_s;
  logic [3:0]       ol_s;
  logic             sync_s;
  logic             normal;
  logic             lowpwr;
  logic             run;
  logic             aw_hold_r;
  logic             w_hold_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             wr_en;
  logic             cfg_wr;
  logic [31:0]      cw_r [8];
  logic [31:0]      stat_clr;
  logic             uv_flag_r;
  logic             ov_flag_r;
  logic [3:0]       oc_flag_r;
  logic [3:0]       ol_flag_r;
  logic [31:0]      rd_word;
  logic [15:0]      div_cnt_r [3];
  logic [15:0]      div_lim [3];
  logic [2:0]       div_tick;
  logic [5:0]       gen_lvl;
  logic [3:0]       lvl;
  logic [1:0]       wake_sel;
  logic             uv_act;
  logic             uv_shut_r;
  logic             uv_clr;
  logic [3:0]       ov_act;
  logic [3:0]       ov_shut_r;
  logic [3:0]       ov_clr;
  logic [3:0]       ov_dis;
  logic [3:0]       ov_rec;
  logic [3:0]       clr_sel;
  logic [3:0][10:0] oc_cnt_r;
  logic [3:0][14:0] ol_cnt_r;
  logic [3:0]       oc_cond;
  logic [3:0]       ol_cond;
  logic [3:0]       oc_trip;
  logic [3:0]       ol_hit;

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= hs_pkg::ADDR_STAT);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Two-stage synchronisers for pins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_r <= 11'h000;
      pin_r      <= 11'h000;
    end else begin
      pin_meta_r <= {sync_i, ol_i, oc_i, ov_i, uv_i};
      pin_r      <= pin_meta_r;
    end
  end

  assign uv_s   = pin_r[0];
  assign ov_s   = pin_r[1];
  assign oc_s   = pin_r[5:2];
  assign ol_s   = pin_r[9:6];
  assign sync_s = pin_r[10];

  assign normal = (mode_i == hs_pkg::MODE_NORMAL);
  assign lowpwr = (mode_i == hs_pkg::MODE_STOP) || (mode_i == hs_pkg::MODE_SLEEP);
  assign run    = normal || lowpwr;

  // Write address and data channels
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      awready_o <= 1'b1;
    end else if (awvalid_i && awready_o) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= awaddr_i;
      awready_o <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      aw_hold_r <= 1'b0;
      awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      wready_o <= 1'b1;
    end else if (wvalid_i && wready_o) begin
      w_hold_r <= 1'b1;
      w_data_r <= wdata_i;
      w_strb_r <= wstrb_i;
      wready_o <= 1'b0;
    end else if (bvalid_o && bready_i) begin
      w_hold_r <= 1'b0;
      wready_o <= 1'b1;
    end
  end

  assign wr_en  = aw_hold_r && w_hold_r && !bvalid_o;
  assign cfg_wr = wr_en && normal && (aw_addr_r < hs_pkg::ADDR_STAT)
                  && (aw_addr_r[1:0] == 2'b00);

  // Write response
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= 2'b00;
    end else if (wr_en) begin
      bvalid_o <= 1'b1;
      bresp_o  <= mapped(aw_addr_r) ? 2'b00 : 2'b10;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // Configuration words; hardware clears of source fields win
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int r = 0; r < 8; r++) begin
        cw_r[r] <= hs_pkg::REG_RST;
      end
    end else begin
      if (cfg_wr) begin
        cw_r[aw_addr_r[4:2]] <= merge(cw_r[aw_addr_r[4:2]], w_data_r, w_strb_r)
                                & hs_pkg::REG_MASK[aw_addr_r[4:2]];
      end
      for (int i = 0; i < 4; i++) begin
        if (clr_sel[i]) begin
          cw_r[hs_pkg::IDX_SEL][4*i +: 4] <= hs_pkg::SRC_OFF;
        end
      end
    end
  end

  assign stat_clr = (wr_en && aw_addr_r == hs_pkg::ADDR_STAT)
                    ? merge(32'h0000_0000, w_data_r, w_strb_r) : 32'h0000_0000;

  // Sticky status flags, set beats clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_flag_r <= 1'b0;
      ov_flag_r <= 1'b0;
      oc_flag_r <= 4'h0;
      ol_flag_r <= 4'h0;
    end else begin
      uv_flag_r <= uv_s || (uv_flag_r && !stat_clr[hs_pkg::ST_UV]);
      ov_flag_r <= ov_s || (ov_flag_r && !stat_clr[hs_pkg::ST_OV]);
      oc_flag_r <= oc_trip | (oc_flag_r & ~stat_clr[hs_pkg::ST_OC +: 4]);
      ol_flag_r <= ol_hit | (ol_flag_r & ~stat_clr[hs_pkg::ST_OL +: 4]);
    end
  end

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr_i == hs_pkg::ADDR_STAT) begin
      rd_word[hs_pkg::ST_UV]      = uv_flag_r;
      rd_word[hs_pkg::ST_OV]      = ov_flag_r;
      rd_word[hs_pkg::ST_OC +: 4] = oc_flag_r;
      rd_word[hs_pkg::ST_OL +: 4] = ol_flag_r;
    end else if (mapped(araddr_i)) begin
      rd_word = cw_r[araddr_i[4:2]];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= 2'b00;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rdata_o   <= rd_word;
      rresp_o   <= mapped(araddr_i) ? 2'b00 : 2'b10;
    end else if (rvalid_o && rready_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
    end
  end

  // Tick dividers: fast PWM, slow PWM, timer
  assign div_lim[0] = hs_pkg::PWM_DIV_FAST;
  assign div_lim[1] = hs_pkg::PWM_DIV_SLOW;
  assign div_lim[2] = 16'(TMR_DIV);

  generate
    for (genvar d = 0; d < 3; d++) begin : g_div
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          div_cnt_r[d] <= 16'h0000;
        end else begin
          div_cnt_r[d] <= div_tick[d] ? 16'h0000 : div_cnt_r[d] + 16'h0001;
        end
      end
      assign div_tick[d] = (div_cnt_r[d] >= div_lim[d] - 16'h0001);
    end

    // PWM generators then the two timers
    for (genvar g = 0; g < 6; g++) begin : g_gen
      logic [31:0] w;
      assign w = cw_r[(g < 4) ? hs_pkg::IDX_PWM1 + 3'(g) : hs_pkg::IDX_TMR1 + 3'(g - 4)];
      duty_gen u_gen (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .tick_i   ((g < 4) ? div_tick[w[hs_pkg::PWM_FREQ]] : div_tick[2]),
        .period_i ((g < 4) ? hs_pkg::PWM_PERIOD : w[9:0]),
        .duty_i   ((g < 4) ? w[9:0] : w[hs_pkg::TMR_DUTY +: 10]),
        .level_o  (gen_lvl[g])
      );
    end
  endgenerate

  assign wake_sel = cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_WAKE +: 2];
  assign ov_dis   = cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_OV_DIS +: 4];
  assign ov_rec   = cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_OV_REC +: 4];

  // Source multiplexer per output
  always_comb begin
    lvl = 4'h0;
    for (int i = 0; i < 4; i++) begin
      case (cw_r[hs_pkg::IDX_SEL][4*i +: 4])
        hs_pkg::SRC_OFF:  lvl[i] = 1'b0;
        hs_pkg::SRC_ON:   lvl[i] = 1'b1;
        hs_pkg::SRC_TMR1: lvl[i] = gen_lvl[4];
        hs_pkg::SRC_TMR2: lvl[i] = gen_lvl[5];
        hs_pkg::SRC_PWM1: lvl[i] = gen_lvl[0];
        hs_pkg::SRC_PWM2: lvl[i] = gen_lvl[1];
        hs_pkg::SRC_PWM3: lvl[i] = gen_lvl[2];
        hs_pkg::SRC_PWM4: lvl[i] = gen_lvl[3];
        hs_pkg::SRC_SYNC: lvl[i] = sync_s && (wake_sel == hs_pkg::WAKE_SYNC);
        default:          lvl[i] = 1'b0;
      endcase
    end
  end

  // Supply shutdown conditions
  assign uv_act = uv_s && !cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_UV_DIS];
  assign uv_clr = uv_shut_r && !uv_act
                  && !cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_UV_REC];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (normal) begin
        ov_act[i] = ov_s && !ov_dis[i];
      end else if (lowpwr) begin
        ov_act[i] = ov_s && !cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_LP_OV_DIS];
      end else begin
        ov_act[i] = ov_s;
      end
    end
  end

  assign ov_clr  = ov_shut_r & ~ov_act & ~ov_rec;
  assign clr_sel = oc_trip | ov_clr | {4{uv_clr}};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_shut_r <= 1'b0;
      ov_shut_r <= 4'h0;
    end else begin
      uv_shut_r <= uv_act;
      ov_shut_r <= ov_act;
    end
  end

  // Overcurrent and open-load filters
  assign oc_cond = oc_s & hs_on_o;
  assign ol_cond = ol_s & hs_on_o;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oc_trip[i] = oc_cond[i] && (oc_cnt_r[i] == 11'(hs_pkg::OC_CYC - 1));
      ol_hit[i]  = ol_cond[i] && (ol_cnt_r[i] == 15'(OL_CYC - 1));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oc_cnt_r <= '0;
      ol_cnt_r <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        oc_cnt_r[i] <= (oc_cond[i] && !oc_trip[i]) ? oc_cnt_r[i] + 11'h001 : 11'h000;
        if (!ol_cond[i]) begin
          ol_cnt_r[i] <= 15'h0000;
        end else if (!ol_hit[i]) begin
          ol_cnt_r[i] <= ol_cnt_r[i] + 15'h0001;
        end
      end
    end
  end

  // Output stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hs_on_o <= 4'h0;
    end else begin
      hs_on_o <= {4{run}} & lvl & ~{4{uv_act}} & ~ov_act & ~oc_trip;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_en_o <= 1'b0;
    end else begin
      wake_en_o <= (wake_sel != hs_pkg::WAKE_SYNC) && (wake_sel != hs_pkg::WAKE_OFF);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_cfg_frozen;
    wr_en && !normal |=> $stable(cw_r[hs_pkg::IDX_CFG]);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed outside normal");

  property p_mode_off;
    (mode_i == hs_pkg::MODE_RESTART) || (mode_i == hs_pkg::MODE_FAILSAFE) |=> hs_on_o == 4'h0;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("output on in restart or fail-safe");

  property p_uv_off;
    uv_act |=> hs_on_o == 4'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("output on during undervoltage");

  property p_uv_clear;
    uv_clr |=> cw_r[hs_pkg::IDX_SEL][15:0] == 16'h0000;
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("sources kept after undervoltage");

  property p_ov_norm;
    normal && ov_s |=> (hs_on_o & ~$past(ov_dis)) == 4'h0;
  endproperty
  a_ov_norm: assert property (p_ov_norm) else $error("output on during normal overvoltage");

  property p_ov_lp;
    lowpwr && ov_s && !cw_r[hs_pkg::IDX_CFG][hs_pkg::CFG_LP_OV_DIS] |=> hs_on_o == 4'h0;
  endproperty
  a_ov_lp: assert property (p_ov_lp) else $error("output on in low-power overvoltage");

  property p_ov_clear;
    ov_clr[2] |=> cw_r[hs_pkg::IDX_SEL][11:8] == 4'h0 ##1 !hs_on_o[2];
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("output 2 source kept after overvoltage");

  property p_oc_trip;
    oc_trip[2] |=> !hs_on_o[2] && oc_flag_r[2] && cw_r[hs_pkg::IDX_SEL][11:8] == 4'h0;
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent trip incomplete");

  property p_ol_hold;
    ol_flag_r[3] && !stat_clr[hs_pkg::ST_OL + 3] |=> ol_flag_r[3];
  endproperty
  a_ol_hold: assert property (p_ol_hold) else $error("open-load flag lost");

  property p_wake_off;
    wake_sel == hs_pkg::WAKE_SYNC |=> !wake_en_o;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake enabled with sync selected");

  property p_oc_restart;
    !oc_cond[0] |=> oc_cnt_r[0] == 11'h000;
  endproperty
  a_oc_restart: assert property (p_oc_restart) else $error("overcurrent filter not restarted");
endmodule : hs_switch_ctrl
`default_nettype wire

// ---- logic/hs_pkg.sv ----
// Package: constants for the high-side switch control block
// Behaviour
// - Output configuration is written in Normal mode; frozen in Stop and Sleep.
// - Entering Restart or Fail-Safe disables all four outputs.
// - Supply undervoltage turns all on outputs off unless shutdown disabled.
// - After undervoltage, resume if recovery set, else stay off and clear control.
// - Undervoltage sets only the undervoltage flag.
// - Normal mode overvoltage turns an output off unless its disable bit set.
// - Stop/Sleep overvoltage keeps outputs on only with the low-power disable bit.
// - After overvoltage, resume per output recovery bit, else off and cleared.
// - Overvoltage sets only the overvoltage flag.
// - Overcurrent held beyond 16 us filter time switches the output off.
// - Overcurrent trip sets its flag and resets the 4-bit source field to 0000.
// - Undercurrent held 220 us sets the open-load flag; output stays on.
// - Open-load flags stay set until software clears them.
// - Source per output: off, on, timer 1/2, PWM 1-4 or sync pin.
// - Static on and off work in Normal, Stop and Sleep.
// - Two timers with independent period and duty drive mapped outputs.
// - Four PWM generators with 10-bit duty and a choice of two frequencies.
// - PWM appears on an output as soon as the generator is assigned.
// - Wake field value 10 selects sync and disables wake on the shared pin.
`default_nettype none
package hs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int OC_FILT_US = 16;
  localparam int OC_CYC = OC_FILT_US * CLK_MHZ;
  localparam int OL_FILT_US = 220;
  localparam int OL_CYC = OL_FILT_US * CLK_MHZ;
  localparam int TMR_DIV = 50000;
  localparam logic [15:0] PWM_DIV_FAST = 16'h000A;
  localparam logic [15:0] PWM_DIV_SLOW = 16'h0032;
  localparam logic [9:0] PWM_PERIOD = 10'h3FF;

  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [2:0] IDX_SEL = 3'h0;
  localparam logic [2:0] IDX_CFG = 3'h1;
  localparam logic [2:0] IDX_TMR1 = 3'h2;
  localparam logic [2:0] IDX_PWM1 = 3'h4;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [31:0] REG_MASK [8] = '{32'h0000_FFFF, 32'h0000_FF37,
    32'h03FF_03FF, 32'h03FF_03FF, 32'h0000_07FF, 32'h0000_07FF,
    32'h0000_07FF, 32'h0000_07FF};

  localparam int CFG_UV_DIS = 0;
  localparam int CFG_UV_REC = 1;
  localparam int CFG_LP_OV_DIS = 2;
  localparam int CFG_WAKE = 4;
  localparam int CFG_OV_DIS = 8;
  localparam int CFG_OV_REC = 12;
  localparam int TMR_DUTY = 16;
  localparam int PWM_FREQ = 10;
  localparam int ST_UV = 0;
  localparam int ST_OV = 1;
  localparam int ST_OC = 4;
  localparam int ST_OL = 8;

  localparam logic [1:0] WAKE_OFF = 2'b00;
  localparam logic [1:0] WAKE_SYNC = 2'b10;

  typedef enum logic [3:0] {
    SRC_OFF = 4'h0, SRC_ON = 4'h1, SRC_TMR1 = 4'h2, SRC_TMR2 = 4'h3,
    SRC_PWM1 = 4'h4, SRC_PWM2 = 4'h5, SRC_PWM3 = 4'h6, SRC_PWM4 = 4'h7,
    SRC_SYNC = 4'h8
  } src_e;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_STOP = 3'h1, MODE_SLEEP = 3'h3,
    MODE_RESTART = 3'h2, MODE_FAILSAFE = 3'h6
  } mode_e;
endpackage : hs_pkg
`default_nettype wire

// ---- logic/duty_gen.sv ----
// Module: period and duty counter for timers and PWM generators
`timescale 1ns/1ns
`default_nettype none
module duty_gen (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       tick_i,
  input  wire logic [9:0] period_i,
  input  wire logic [9:0] duty_i,
  output logic            level_o
);
  logic [9:0] cnt_r;

  // Count ticks across one period
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 10'h000;
    end else if (tick_i) begin
      cnt_r <= (cnt_r >= period_i) ? 10'h000 : cnt_r + 10'h001;
    end
  end

  // On phase while count below duty
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
    end else begin
      level_o <= (cnt_r < duty_i);
    end
  end
endmodule : duty_gen
`default_nettype wire

// ---- verification/load_model.sv ----
// Load model: switch loads with commanded shorts and open circuits
`timescale 1ns/1ns
`default_nettype none
module load_model (
  input  wire logic [3:0] hs_on_i,
  input  wire logic [3:0] short_i,
  input  wire logic [3:0] open_i,
  output logic [3:0]      oc_o,
  output logic [3:0]      ol_o
);
  // Overcurrent only through a closed switch
  assign oc_o = hs_on_i & short_i;
  // An open switch carries no current
  assign ol_o = open_i | ~hs_on_i;
endmodule : load_model
`default_nettype wire

// ---- verification/high_side_switch_control_tb_top.sv ----
// Testbench: switch control against a register and output model
`timescale 1ns/1ns
`default_nettype none
module high_side_switch_control_tb_top;
  logic        clk_i, rstn_i, uv_i, ov_i, sync_i, wake_en_o;
  logic [2:0]  mode_i;
  logic [3:0]  short_r, open_r, oc_i, ol_i, hs_on_o, wstrb_i;
  logic [7:0]  awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o, rnd_r;
  logic        awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0]  bresp_o, rresp_o;
  logic [31:0] mdl [8];
  int          err_count, samples_checked;

  hs_switch_ctrl #(.OL_CYC(40), .TMR_DIV(4)) u_dut (.clk_i, .rstn_i, .mode_i, .uv_i, .ov_i, .oc_i, .ol_i,
    .sync_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o,
    .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
    .hs_on_o, .wake_en_o);
  load_model u_load (.hs_on_i(hs_on_o), .short_i(short_r), .open_i(open_r), .oc_o(oc_i), .ol_o(ol_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] act);
    samples_checked++;
    if (act !== exp) begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : chk_word

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic chk_out(input logic [3:0] exp);
    step(8);
    @(negedge clk_i);
    samples_checked++;
    if (hs_on_o !== exp) begin
      err_count++;
      $display("wrong value at %0t: outputs expected %h got %h", $time, exp, hs_on_o);
    end
    @(posedge clk_i);
  endtask : chk_out

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a[1:0] != 2'h0 || a > 8'h20) ? 2'b10 : 2'b00;
  endfunction : resp_of

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= 4'hF;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge clk_i);
      ta = awvalid_i && awready_o;
      tw = wvalid_i && wready_o;
      tb = bvalid_o;
      r = bresp_o;
      @(posedge clk_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
      if (tb) bready_i <= 1'b0;
    end
    if (!tb) err_count++;
    chk_word({30'h0, resp_of(a)}, {30'h0, r});
    if (a < 8'h20 && a[1:0] == 2'h0 && mode_i == hs_pkg::MODE_NORMAL) mdl[a[4:2]] = d & hs_pkg::REG_MASK[a[4:2]];
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge clk_i);
      ta = arvalid_i && arready_o;
      tr = rvalid_o;
      d = rdata_o;
      r = rresp_o;
      @(posedge clk_i);
      if (ta) arvalid_i <= 1'b0;
      if (tr) rready_i <= 1'b0;
    end
    if (!tr) err_count++;
    chk_word({30'h0, resp_of(a)}, {30'h0, r});
    chk_word(exp, d);
  endtask : rd

  task automatic cnt(input int b, input int cyc, input int lo, input int hi);
    int h;
    h = 0;
    repeat (cyc) begin
      @(negedge clk_i);
      if (hs_on_o[b] === 1'b1) h++;
    end
    chk_word(32'h1, {31'h0, h >= lo && h <= hi});
  endtask : cnt

  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    {rstn_i, uv_i, ov_i, sync_i, mode_i, short_r, open_r, wstrb_i} = '0;
    {awaddr_i, araddr_i, wdata_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    err_count = 0;
    samples_checked = 0;
    rnd_r = 32'hB56C;
    for (int i = 0; i < 8; i++) mdl[i] = hs_pkg::REG_RST;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(i * 4), hs_pkg::REG_RST);
    rd(8'h24, 32'h0);
    wr(8'h24, 32'hFFFF_FFFF);
    wr(8'h06, 32'hFFFF_FFFF);
    for (int i = 2; i < 8; i++) begin
      rnd_r = xs(rnd_r);
      wr(8'(i * 4), rnd_r);
      rd(8'(i * 4), mdl[i]);
    end
    wr(hs_pkg::ADDR_SEL, 32'h1111);
    chk_out(4'hF);
    mode_i <= hs_pkg::MODE_STOP;
    wr(hs_pkg::ADDR_SEL, 32'h0);
    rd(hs_pkg::ADDR_SEL, mdl[0]);
    chk_out(4'hF);
    mode_i <= hs_pkg::MODE_SLEEP;
    chk_out(4'hF);
    mode_i <= hs_pkg::MODE_RESTART;
    chk_out(4'h0);
    mode_i <= hs_pkg::MODE_FAILSAFE;
    chk_out(4'h0);
    mode_i <= hs_pkg::MODE_NORMAL;
    chk_out(4'hF);
    uv_i <= 1'b1;
    chk_out(4'h0);
    rd(hs_pkg::ADDR_STAT, 32'h1);
    uv_i <= 1'b0;
    chk_out(4'h0);
    mdl[0] = 32'h0;
    rd(hs_pkg::ADDR_SEL, mdl[0]);
    wr(hs_pkg::ADDR_STAT, 32'hFFF);
    rd(hs_pkg::ADDR_STAT, 32'h0);
    wr(hs_pkg::ADDR_CFG, 32'h2);
    wr(hs_pkg::ADDR_SEL, 32'h1111);
    uv_i <= 1'b1;
    chk_out(4'h0);
    uv_i <= 1'b0;
    chk_out(4'hF);
    wr(hs_pkg::ADDR_CFG, 32'h3);
    uv_i <= 1'b1;
    chk_out(4'hF);
    uv_i <= 1'b0;
    rd(hs_pkg::ADDR_SEL, mdl[0]);
    wr(hs_pkg::ADDR_CFG, 32'h3100);
    wr(hs_pkg::ADDR_STAT, 32'hFFF);
    ov_i <= 1'b1;
    chk_out(4'h1);
    rd(hs_pkg::ADDR_STAT, 32'h2);
    ov_i <= 1'b0;
    chk_out(4'h3);
    mdl[0] = 32'h0011;
    rd(hs_pkg::ADDR_SEL, mdl[0]);
    wr(hs_pkg::ADDR_SEL, 32'h1111);
    wr(hs_pkg::ADDR_CFG, 32'hF004);
    mode_i <= hs_pkg::MODE_STOP;
    ov_i <= 1'b1;
    chk_out(4'hF);
    ov_i <= 1'b0;
    mode_i <= hs_pkg::MODE_NORMAL;
    wr(hs_pkg::ADDR_CFG, 32'hF000);
    mode_i <= hs_pkg::MODE_STOP;
    ov_i <= 1'b1;
    chk_out(4'h0);
    ov_i <= 1'b0;
    chk_out(4'hF);
    mode_i <= hs_pkg::MODE_NORMAL;
    wr(hs_pkg::ADDR_STAT, 32'hFFF);
    short_r <= 4'h4;
    step(1500);
    short_r <= 4'h0;
    step(5);
    short_r <= 4'h4;
    step(1500);
    chk_out(4'hF);
    step(200);
    chk_out(4'hB);
    short_r <= 4'h0;
    mdl[0] = 32'h1011;
    rd(hs_pkg::ADDR_SEL, mdl[0]);
    rd(hs_pkg::ADDR_STAT, 32'h40);
    wr(hs_pkg::ADDR_SEL, 32'h1111);
    chk_out(4'hF);
    rd(hs_pkg::ADDR_STAT, 32'h40);
    wr(hs_pkg::ADDR_STAT, 32'h40);
    rd(hs_pkg::ADDR_STAT, 32'h0);
    open_r <= 4'h8;
    step(60);
    rd(hs_pkg::ADDR_STAT, 32'h800);
    chk_out(4'hF);
    open_r <= 4'h0;
    rd(hs_pkg::ADDR_STAT, 32'h800);
    wr(hs_pkg::ADDR_STAT, 32'h800);
    rd(hs_pkg::ADDR_STAT, 32'h0);
    wr(8'h10, 32'h200);
    wr(8'h08, 32'h0005_0009);
    wr(8'h0C, 32'h0005_0009);
    wr(hs_pkg::ADDR_SEL, 32'h3214);
    cnt(0, 10240, 5100, 5140);
    cnt(2, 400, 192, 208);
    cnt(3, 400, 192, 208);
    wr(hs_pkg::ADDR_CFG, 32'h20);
    wr(hs_pkg::ADDR_SEL, 32'h80);
    sync_i <= 1'b1;
    chk_out(4'h2);
    @(negedge clk_i) chk_word(32'h0, {31'h0, wake_en_o});
    @(posedge clk_i) sync_i <= 1'b0;
    chk_out(4'h0);
    wr(hs_pkg::ADDR_CFG, 32'h10);
    sync_i <= 1'b1;
    chk_out(4'h0);
    @(negedge clk_i) chk_word(32'h1, {31'h0, wake_en_o});
    end_of_test();
  end
endmodule : high_side_switch_control_tb_top
`default_nettype wire
